// ===== rtl/radio_core_deep_sleep_wake.sv
// Deep-sleep entry and exit control with exchange-memory bounds checking
`timescale 1ns/1ps
// Summary of operation
// R1 - Exchange memory maps onto physical memories by one of 24 cases of 2 kB pages.
// R2 - Out-of-region core access sets the access-error flag and error interrupt.
// R3 - Writing one to the clear bit clears the access-error flag.
// R4 - Error interrupt is high while access-error or general error flag is set.
// R5 - Sleep exit always gives early wake interrupt first, then sleep-exit interrupt.
// R6 - Early wake rises wake-set-lead sleep cycles before timer expiry.
// R7 - Too small wake-set-lead still wakes; recorded duration grows.
// R8 - Early wake falls wake-clear-lead sleep cycles before period end.
// R9 - External wake holds early wake high per external pulse length field.
// R10 - Early wake rises at once when software sets the external wake request.
// R11 - Software programs duration at least wake-set-lead plus one and its own latency.
// R12 - On entry the timing reference switches to the sleep clock.
// R13 - Software programs wake timing, then duration, then sets deep-sleep enable.
// R14 - Power-down-allowed rises after the clock switch; software polls it.
// R15 - Software then gates core clocks and may power down the radio.
// R16 - After expiry, sleep lasts until core is clocked and powered; longer time recorded.
// R17 - Exit with sleep-exit interrupt when expired, clocks enabled and radio powered.
// R18 - Deep sleep is not entered while the external wake request is high.
// R19 - External wake disable bit makes the device ignore the wake request.
// R20 - Sleep-clock cycles are counted per sleep and readable as last sleep length.
module radio_core_deep_sleep_wake (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Sleep clock and system status
  input  wire logic        sleep_clock,
  input  wire logic        core_clk_enabled,
  input  wire logic        radio_powered_flag,
  input  wire logic        general_error_flag,
  // Core access to exchange memory
  input  wire logic        exch_access_valid,
  input  wire logic [16:0] exch_access_addr,
  // Interrupts and power status
  output logic             early_wake_interrupt,
  output logic             sleep_exit_interrupt,
  output logic             core_error_interrupt,
  output logic             sleep_timebase_select,
  output logic             power_down_allowed
);
  typedef enum logic [1:0] {ACTIVE, SWITCHING, SLEEPING, EXPIRED} state_type;

  // Size of exchange region for a mapping case, zero for an illegal case
  function automatic logic [16:0] region_limit(input logic [4:0] map_case);
    logic [16:0] pages;
    pages = {12'h000, map_case} + 17'h00001;
    if (map_case >= sleep_wake_pkg::MAP_CASES)
      region_limit = 17'h00000;
    else
      region_limit = 17'((pages * sleep_wake_pkg::PAGE_BYTES));
  endfunction : region_limit

  state_type                     state_q;
  logic                          sleep_on_q;
  logic                          ext_disable_q;
  logic                          wake_req_q;
  logic                          wake_req_prev_q;
  logic [4:0]                    map_case_q;
  logic [31:0]                   sleep_length_q;
  sleep_wake_pkg::wake_timing_type timing_q;
  logic [31:0]                   remain_q;
  logic [31:0]                   elapsed_q;
  logic [31:0]                   last_length_q;
  logic                          wake_seen_q;
  logic                          exch_err_q;
  logic                          lp_sample_q;
  logic                          lp_prev_q;

  // Bus decode
  wire        setup_phase = psel & ~penable;
  wire        access_done = psel & penable & pready;
  wire        wr_en       = access_done & pwrite;
  wire        sel_ctrl    = paddr == sleep_wake_pkg::SLEEP_CONTROL_OFS;
  wire        sel_len     = paddr == sleep_wake_pkg::SLEEP_LENGTH_SETTING_OFS;
  wire        sel_last    = paddr == sleep_wake_pkg::LAST_SLEEP_LENGTH_OFS;
  wire        sel_timing  = paddr == sleep_wake_pkg::WAKE_TIMING_SETTING_OFS;
  wire        sel_gen     = paddr == sleep_wake_pkg::GENERAL_CONTROL_OFS;
  wire        sel_err     = paddr == sleep_wake_pkg::ERROR_STATUS_OFS;
  wire        mapped      = sel_ctrl | sel_len | sel_last | sel_timing | sel_gen | sel_err;

  // Sleep clock rising edge as a one-cycle tick
  wire        lp_tick     = lp_sample_q & ~lp_prev_q;

  // Exchange memory bounds check
  wire        exch_violation = exch_access_valid &
                               (exch_access_addr >= region_limit(map_case_q)); // see R1
  wire        exch_clear  = wr_en & sel_err & pwdata[sleep_wake_pkg::EXCH_CLEAR_BIT];

  // External wake request, masked by the disable bit
  wire        ext_active  = wake_req_q & ~ext_disable_q; // see R19
  wire        ext_rise    = ext_active & ~wake_req_prev_q;
  wire        asleep      = (state_q == SWITCHING) | (state_q == SLEEPING);
  wire [31:0] remain_dec  = remain_q - 32'h0000_0001;
  wire [31:0] set_lead32  = {21'h000000, timing_q.set_lead};
  wire [31:0] clear_lead32 = {22'h000000, timing_q.clear_lead};
  wire        exit_ok     = (state_q == EXPIRED) & core_clk_enabled &
                            radio_powered_flag & wake_seen_q; // see R17
  wire        enter_req   = (state_q == ACTIVE) & sleep_on_q & ~ext_active; // see R18

  // Read data mux
  logic [31:0] rd_data;
  assign rd_data =
    sel_ctrl   ? {28'h0000000, state_q != ACTIVE, power_down_allowed, ext_disable_q,
                  sleep_on_q} :
    sel_len    ? sleep_length_q :
    sel_last   ? last_length_q :
    sel_timing ? timing_q :
    sel_gen    ? {23'h000000, wake_req_q, 3'h0, map_case_q} :
    sel_err    ? {29'h00000000, general_error_flag, 1'b0, exch_err_q} :
                 32'h0000_0000;

  // APB answer: ready in the access phase, data captured in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup_phase;
      prdata  <= rd_data;
      pslverr <= setup_phase & ~mapped;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_length_q <= sleep_wake_pkg::SLEEP_LENGTH_RESET;
      timing_q       <= sleep_wake_pkg::WAKE_TIMING_RESET;
      map_case_q     <= sleep_wake_pkg::MAP_CASE_RESET;
      wake_req_q     <= 1'b0;
      ext_disable_q  <= 1'b0;
    end
    else if (wr_en)
    begin
      if (sel_len)
        sleep_length_q <= pwdata;
      if (sel_timing)
        timing_q <= pwdata;
      if (sel_gen)
      begin
        map_case_q <= pwdata[sleep_wake_pkg::MAP_CASE_LSB +: sleep_wake_pkg::MAP_CASE_W];
        wake_req_q <= pwdata[sleep_wake_pkg::WAKE_REQ_BIT];
      end
      if (sel_ctrl)
        ext_disable_q <= pwdata[sleep_wake_pkg::EXT_DISABLE_BIT];
    end
  end

  // Access error flag: a new violation wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      exch_err_q <= 1'b0;
    else if (exch_violation)
      exch_err_q <= 1'b1; // see R2
    else if (exch_clear)
      exch_err_q <= 1'b0; // see R3
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_error_interrupt <= 1'b0;
    else
      core_error_interrupt <= exch_err_q | general_error_flag; // see R4
  end

  // Sleep clock sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lp_sample_q     <= 1'b0;
      lp_prev_q       <= 1'b0;
      wake_req_prev_q <= 1'b0;
    end
    else
    begin
      lp_sample_q     <= sleep_clock;
      lp_prev_q       <= lp_sample_q;
      wake_req_prev_q <= ext_active;
    end
  end

  // Sleep sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q               <= ACTIVE;
      sleep_on_q            <= 1'b0;
      remain_q              <= 32'h0000_0000;
      elapsed_q             <= 32'h0000_0000;
      last_length_q         <= 32'h0000_0000;
      wake_seen_q           <= 1'b0;
      early_wake_interrupt  <= 1'b0;
      sleep_exit_interrupt  <= 1'b0;
      sleep_timebase_select <= 1'b0;
      power_down_allowed    <= 1'b0;
    end
    else
    begin
      sleep_exit_interrupt <= 1'b0;
      if (wr_en && sel_ctrl && pwdata[sleep_wake_pkg::SLEEP_ON_BIT])
        sleep_on_q <= 1'b1;
      unique case (state_q)
        ACTIVE:
          if (enter_req)
          begin
            state_q               <= SWITCHING;
            sleep_timebase_select <= 1'b1; // see R12
            remain_q              <= sleep_length_q;
            elapsed_q             <= 32'h0000_0000;
            wake_seen_q           <= 1'b0;
          end
        SWITCHING:
          if (lp_tick)
          begin
            state_q            <= SLEEPING;
            power_down_allowed <= 1'b1; // see R14
          end
        SLEEPING:
          if (lp_tick)
          begin
            elapsed_q <= elapsed_q + 32'h0000_0001; // see R20
            remain_q  <= remain_dec;
            if (remain_q <= 32'h0000_0001)
              state_q <= EXPIRED;
            if (remain_dec == set_lead32 || (remain_q <= set_lead32 && !wake_seen_q))
            begin
              early_wake_interrupt <= 1'b1; // see R6
              wake_seen_q          <= 1'b1;
            end
            if (remain_dec == clear_lead32 && wake_seen_q)
              early_wake_interrupt <= 1'b0; // see R8
          end
        EXPIRED:
        begin
          if (lp_tick)
            elapsed_q <= elapsed_q + 32'h0000_0001; // see R16
          if (!wake_seen_q)
          begin
            early_wake_interrupt <= 1'b1; // see R7
            wake_seen_q          <= 1'b1;
          end
          else if (exit_ok)
          begin
            state_q               <= ACTIVE;
            early_wake_interrupt  <= 1'b0;
            sleep_exit_interrupt  <= 1'b1; // see R5
            sleep_timebase_select <= 1'b0;
            power_down_allowed    <= 1'b0;
            sleep_on_q            <= 1'b0;
            last_length_q         <= elapsed_q; // see R20
          end
        end
      endcase
      // External wake restarts the countdown with the pulse length
      if (asleep && ext_rise)
      begin
        if (state_q == SWITCHING)
          state_q <= SLEEPING;
        power_down_allowed   <= 1'b1;
        early_wake_interrupt <= 1'b1; // see R10
        wake_seen_q          <= 1'b1;
        remain_q             <= {21'h000000, timing_q.ext_len}; // see R9
      end
    end
  end

  // Checks
  a_access_err_set: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    exch_violation |=> exch_err_q) else $error("access error flag not set");
  a_err_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    exch_err_q && $stable(exch_err_q) |=> core_error_interrupt)
    else $error("error interrupt missing");
  a_err_clear_ack: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    exch_clear && !exch_violation |=> !exch_err_q) else $error("access error not cleared");
  a_exit_after_wake: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    $rose(sleep_exit_interrupt) |-> $past(wake_seen_q) && !early_wake_interrupt)
    else $error("sleep exit before early wake");
  a_exit_conditions: assert property (@(posedge pclk) disable iff (!presetn) // see R17
    exit_ok |=> sleep_exit_interrupt ##1 !sleep_exit_interrupt && state_q == ACTIVE)
    else $error("sleep exit not signalled");
  a_ext_wake_fast: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    asleep && ext_rise |=> early_wake_interrupt) else $error("external wake late");
  a_refuse_entry: assert property (@(posedge pclk) disable iff (!presetn) // see R18
    state_q == ACTIVE && ext_active |=> state_q == ACTIVE) else $error("sleep entered");
  a_set_lead_rise: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    state_q == SLEEPING && lp_tick && remain_dec == set_lead32 && !ext_rise
    && remain_dec != clear_lead32 |=> early_wake_interrupt) else $error("early wake missed");
  a_pd_allowed: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    power_down_allowed |-> sleep_timebase_select) else $error("power down without switch");
  c_timer_exit: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == SLEEPING ##1 state_q == EXPIRED ##[1:1000] sleep_exit_interrupt);
  c_ext_wake: cover property (@(posedge pclk) disable iff (!presetn)
    asleep && ext_rise ##[1:1000] sleep_exit_interrupt);
  c_access_err: cover property (@(posedge pclk) disable iff (!presetn)
    exch_violation ##2 core_error_interrupt);
endmodule : radio_core_deep_sleep_wake

// ===== rtl/sleep_wake_pkg.sv
// Package of register map, field layout and types for the deep-sleep wake block
package sleep_wake_pkg;
  // Register byte offsets
  localparam logic [7:0] SLEEP_CONTROL_OFS        = 8'h30;
  localparam logic [7:0] SLEEP_LENGTH_SETTING_OFS = 8'h34;
  localparam logic [7:0] LAST_SLEEP_LENGTH_OFS    = 8'h38;
  localparam logic [7:0] WAKE_TIMING_SETTING_OFS  = 8'h3C;
  localparam logic [7:0] GENERAL_CONTROL_OFS      = 8'h40;
  localparam logic [7:0] ERROR_STATUS_OFS         = 8'h44;
  // Sleep control fields
  localparam int SLEEP_ON_BIT      = 0;
  localparam int EXT_DISABLE_BIT   = 1;
  localparam int PD_ALLOWED_BIT    = 2;
  localparam int IN_SLEEP_BIT      = 3;
  // General control fields
  localparam int MAP_CASE_LSB      = 0;
  localparam int MAP_CASE_W        = 5;
  localparam int WAKE_REQ_BIT      = 8;
  // Error status fields
  localparam int EXCH_ERR_BIT      = 0;
  localparam int EXCH_CLEAR_BIT    = 1;
  localparam int GEN_ERR_BIT       = 2;
  // Exchange memory mapping
  localparam logic [4:0]  MAP_CASES  = 5'h18;
  localparam logic [16:0] PAGE_BYTES = 17'h00800;
  // Reset values
  localparam logic [31:0] SLEEP_LENGTH_RESET = 32'h0000_0000;
  localparam logic [4:0]  MAP_CASE_RESET     = 5'h00;
  // Wake interrupt timing, in sleep-clock cycles
  typedef struct packed {
    logic [10:0] ext_len;
    logic [9:0]  clear_lead;
    logic [10:0] set_lead;
  } wake_timing_type;
  localparam wake_timing_type WAKE_TIMING_RESET = '{ext_len: 11'h002, clear_lead: 10'h001,
                                                    set_lead: 11'h010};
endpackage : sleep_wake_pkg

// ===== test/power_ctrl_model.sv
// Power and clock controller model facing the sleep block
`timescale 1ns/1ps
module power_ctrl_model #(
  parameter int WAKE_DLY = 20
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Status from the block
  input  wire logic early_wake_interrupt,
  input  wire logic power_down_allowed,
  // Clock and power levels
  output logic      sleep_clock,
  output logic      core_clk_enabled,
  output logic      radio_powered_flag
);
  logic       on_q;
  logic       cut_q;
  logic       wake_q;
  logic [7:0] cnt_q;
  assign core_clk_enabled   = on_q;
  assign radio_powered_flag = on_q;
  // Sleep oscillator runs free
  initial
  begin
    sleep_clock = 1'b0;
    forever #160 sleep_clock = ~sleep_clock;
  end
  // Gate clocks once allowed, restore a while after early wake
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      on_q   <= 1'b1;
      cut_q  <= 1'b0;
      wake_q <= 1'b0;
      cnt_q  <= 8'h00;
    end
    else
    begin
      if (power_down_allowed && !cut_q)
      begin
        on_q  <= 1'b0;
        cut_q <= 1'b1;
      end
      if (!power_down_allowed)
        cut_q <= 1'b0;
      if (early_wake_interrupt && !on_q)
        wake_q <= 1'b1;
      if (wake_q)
        cnt_q <= cnt_q + 8'h01;
      if (wake_q && cnt_q == 8'(WAKE_DLY))
      begin
        on_q   <= 1'b1;
        wake_q <= 1'b0;
        cnt_q  <= 8'h00;
      end
    end
endmodule : power_ctrl_model

// ===== test/tb.sv
// Self-checking bench of the deep-sleep wake block
`timescale 1ns/1ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, last_rd, lfsr_q;
  logic        exch_access_valid, general_error_flag, sleep_clock, ew_seen;
  logic [16:0] exch_access_addr, a;
  logic        early_wake_interrupt, sleep_exit_interrupt, core_error_interrupt;
  logic        sleep_timebase_select, power_down_allowed, core_clk_enabled;
  logic        radio_powered_flag, err;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          err_total, checks, exits, cyc, c;
  int          cases[4] = '{0, 3, 23, 24};

  radio_core_deep_sleep_wake dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .sleep_clock, .core_clk_enabled,
    .radio_powered_flag, .general_error_flag, .exch_access_valid, .exch_access_addr,
    .early_wake_interrupt, .sleep_exit_interrupt, .core_error_interrupt,
    .sleep_timebase_select, .power_down_allowed);
  power_ctrl_model pwr_u (.pclk, .presetn, .early_wake_interrupt, .power_down_allowed,
    .sleep_clock, .core_clk_enabled, .radio_powered_flag);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w)
      last_rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] ad, input logic [32:0] exp, input logic skip);
    exp_q.push_back({skip, exp});
    apb(1'b0, ad, 32'h0);
  endtask : rd

  task automatic poll_sleep();
    do rd(8'h30, 33'h0, 1'b1); while (last_rd[2] !== 1'b1);
    chk(33'(sleep_timebase_select), 33'h1, "timebase");
    chk(33'(power_down_allowed), 33'h1, "power down pin");
  endtask : poll_sleep

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      test_done();
    end
  end

  // Result watcher: exit order and read data
  always @(negedge pclk)
  begin
    if (early_wake_interrupt === 1'b1)
      ew_seen = 1'b1;
    if (sleep_exit_interrupt === 1'b1)
    begin
      chk(33'(ew_seen), 33'h1, "exit before early wake");
      ew_seen = 1'b0;
      exits++;
    end
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (!e[33])
        chk({pslverr, prdata}, e[32:0], "read data");
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    exch_access_valid = 1'b0;
    exch_access_addr = 17'h0;
    general_error_flag = 1'b0;
    ew_seen = 1'b0;
    lfsr_q = 32'hAD5DD524;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h3C, {1'b0, sleep_wake_pkg::WAKE_TIMING_RESET}, 1'b0);
    rd(8'h00, {1'b1, 32'h0}, 1'b0);
    apb(1'b1, 8'h38, 32'hFFFF);
    rd(8'h38, 33'h0, 1'b0);
    $display("test registers done");
    apb(1'b1, 8'h3C, {11'h002, 10'h001, 11'h002});
    apb(1'b1, 8'h34, 32'h6);
    apb(1'b1, 8'h30, 32'h1);
    poll_sleep();
    wait (exits == 1);
    rd(8'h38, 33'h0, 1'b1);
    chk(33'(last_rd >= 32'h6), 33'h1, "sleep length");
    rd(8'h30, 33'h0, 1'b0);
    $display("test timer wake done");
    apb(1'b1, 8'h34, 32'd1000);
    apb(1'b1, 8'h30, 32'h1);
    poll_sleep();
    apb(1'b1, 8'h40, 32'h100);
    repeat (2) @(negedge pclk);
    chk(33'(early_wake_interrupt), 33'h1, "early wake");
    wait (early_wake_interrupt === 1'b0);
    @(negedge pclk);
    chk(33'(sleep_timebase_select), 33'h1, "ext pulse");
    wait (exits == 2);
    apb(1'b1, 8'h30, 32'h1);
    repeat (40) @(negedge pclk);
    chk(33'(sleep_timebase_select), 33'h0, "entered");
    apb(1'b1, 8'h3C, {11'h002, 10'h001, 11'h000});
    apb(1'b1, 8'h34, 32'd20);
    apb(1'b1, 8'h30, 32'h3);
    poll_sleep();
    apb(1'b1, 8'h40, 32'h0);
    wait (exits == 3);
    rd(8'h38, 33'h0, 1'b1);
    chk(33'(last_rd > 32'h14), 33'h1, "late wake length");
    apb(1'b1, 8'h30, 32'h0);
    $display("test external wake done");
    for (int i = 0; i < 4; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      c = cases[i];
      a = 17'(lfsr_q % ((c + 2) * 2048));
      err = (c >= 24) || (a >= 17'((c + 1) * 2048));
      apb(1'b1, 8'h40, 32'(c));
      @(posedge pclk);
      exch_access_valid <= 1'b1;
      exch_access_addr <= a;
      @(posedge pclk);
      exch_access_valid <= 1'b0;
      repeat (3) @(negedge pclk);
      chk(33'(core_error_interrupt), 33'(err), "error irq");
      rd(8'h44, 33'h0, 1'b1);
      chk(33'(last_rd[0]), 33'(err), "error flag");
      apb(1'b1, 8'h44, 32'h2);
      repeat (3) @(negedge pclk);
      chk(33'(core_error_interrupt), 33'h0, "error clear");
    end
    @(posedge pclk);
    general_error_flag <= 1'b1;
    repeat (3) @(negedge pclk);
    chk(33'(core_error_interrupt), 33'h1, "general irq");
    $display("test errors done");
    test_done();
  end
endmodule : tb
